// File: modulo_defs.svh
// register offsets, field positions, reset values for the circular addressing block
`ifndef MODULO_DEFS_SVH
`define MODULO_DEFS_SVH
`define OFF_CONTROL 8'h00
`define OFF_X_START 8'h04
`define OFF_X_END 8'h08
`define OFF_Y_START 8'h0c
`define OFF_Y_END 8'h10
`define OFF_STATUS 8'h14
`define X_ENABLE_BIT 15
`define Y_ENABLE_BIT 14
`define X_SELECT_LSB 0
`define Y_SELECT_LSB 4
`define SELECT_OFF 4'hf
`define CONTROL_RESET 16'h00ff
`define ADDR_RESET 16'h0000
`define WORD_MASK 16'hfffe
`define FULL_MASK 16'hffff
`endif

// File: modulo_pkg.sv
// types shared by the circular addressing block
package modulo_pkg;
  typedef struct packed {
    logic valid;
    logic prog_space;
    logic [3:0] sel;
    logic [15:0] ptr;
    logic [15:0] step;
  } agu_req_s;
  typedef struct packed {
    logic valid;
    logic prog_space;
    logic wrapped;
    logic [15:0] ea;
    logic [15:0] ptr_next;
  } agu_rsp_s;
endpackage

// File: mode_decode.sv
// decodes one space's enable bit and pointer select field
`timescale 1ns/100ps
`default_nettype none
`include "modulo_defs.svh"
module mode_decode #(
  parameter int EN_BIT = 15,
  parameter int SEL_LSB = 0
) (
  // control word
  input wire logic [15:0] control,
  // decoded mode
  output logic active,
  output logic [3:0] sel
);
  assign sel = control[SEL_LSB +: 4];
  // 1111 in the select field switches the space off even when enabled
  assign active = control[EN_BIT] && (sel != `SELECT_OFF);
endmodule
`default_nettype wire

// File: circular_wrap.sv
// next-pointer calculation for one address generator with boundary correction
`timescale 1ns/100ps
`default_nettype none
`include "modulo_defs.svh"
module circular_wrap (
  // mode of this space
  input wire logic active,
  input wire logic [3:0] sel,
  input wire logic word_only,
  input wire logic [15:0] start_addr,
  input wire logic [15:0] end_addr,
  // pointer update from the core
  input wire modulo_pkg::agu_req_s req,
  // corrected result
  output logic [15:0] ea,
  output logic [15:0] ptr_next,
  output logic wrapped
);
  import modulo_pkg::*;
  wire [15:0] mask = word_only ? `WORD_MASK : `FULL_MASK;
  wire [15:0] s_m = start_addr & mask;
  wire [15:0] e_m = end_addr & mask;
  wire [15:0] base = req.ptr & mask;
  // 18-bit signed sum so moving past either end of the 16-bit space is still seen
  wire signed [17:0] sum = $signed({2'b00, base}) + $signed({{2{req.step[15]}}, req.step});
  wire hit = active && (req.sel == sel);
  wire up = !req.step[15] && (req.step != 16'h0000);
  wire over = up && (sum > $signed({2'b00, e_m}));
  wire under = req.step[15] && (sum < $signed({2'b00, s_m}));
  assign ea = base;
  // up steps are checked against the end and down steps against the start, so power-of-two buffers run either way
  assign wrapped = hit && (over || under);
  assign ptr_next = (hit && over) ? s_m :
    (hit && under) ? e_m :
    (sum[15:0] & mask);
endmodule
`default_nettype wire

// File: modulo_circular_addressing.sv
// circular buffer address correction for the x and y data spaces, apb registers
//
// How it works
// - one independent buffer each in x and y
// - x buffer also serves program-space pointers
// - power-of-two buffers checked at both boundaries
// - separate 16-bit start and end registers
// - y addresses are words, lsb forced clear
// - length from start/end difference, max 32K words
// - x correction needs bit 15 and select not 1111
// - y correction needs bit 14 and select not 1111
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "modulo_defs.svh"
module modulo_circular_addressing (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // x read address generator
  input wire modulo_pkg::agu_req_s x_rd_req,
  output modulo_pkg::agu_rsp_s x_rd_rsp,
  // x write address generator
  input wire modulo_pkg::agu_req_s x_wr_req,
  output modulo_pkg::agu_rsp_s x_wr_rsp,
  // y address generator
  input wire modulo_pkg::agu_req_s y_req,
  output modulo_pkg::agu_rsp_s y_rsp
);
  import modulo_pkg::*;

  // registers
  logic [15:0] modulo_bitrev_control;
  logic [15:0] x_buffer_start_addr;
  logic [15:0] x_buffer_end_addr;
  logic [15:0] y_buffer_start_addr;
  logic [15:0] y_buffer_end_addr;
  logic x_wrap_seen;
  logic y_wrap_seen;

  // apb decode
  wire access = psel && penable;
  wire wr_en = access && pwrite;
  wire rd_en = access && !pwrite;
  wire sel_control = (paddr == `OFF_CONTROL);
  wire sel_x_start = (paddr == `OFF_X_START);
  wire sel_x_end = (paddr == `OFF_X_END);
  wire sel_y_start = (paddr == `OFF_Y_START);
  wire sel_y_end = (paddr == `OFF_Y_END);
  wire sel_status = (paddr == `OFF_STATUS);
  wire mapped = sel_control || sel_x_start || sel_x_end ||
    sel_y_start || sel_y_end || sel_status;
  wire read_clears_status = rd_en && sel_status;
  // one write strobe per register; status has none, so writes there are dropped
  wire wr_control = wr_en && sel_control;
  wire wr_x_start = wr_en && sel_x_start;
  wire wr_x_end = wr_en && sel_x_end;
  wire wr_y_start = wr_en && sel_y_start;
  wire wr_y_end = wr_en && sel_y_end;
  // read data is captured in the setup cycle
  wire rd_setup = psel && !penable && !pwrite;
  wire status_setup = rd_setup && sel_status;

  // every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // mode decode per space
  logic x_active;
  logic [3:0] x_sel;
  logic y_active;
  logic [3:0] y_sel;

  mode_decode #(
    .EN_BIT(`X_ENABLE_BIT),
    .SEL_LSB(`X_SELECT_LSB)
  ) u_x_mode (
    .control(modulo_bitrev_control),
    .active(x_active),
    .sel(x_sel)
  );

  mode_decode #(
    .EN_BIT(`Y_ENABLE_BIT),
    .SEL_LSB(`Y_SELECT_LSB)
  ) u_y_mode (
    .control(modulo_bitrev_control),
    .active(y_active),
    .sel(y_sel)
  );

  // length in words for status; the 16-bit byte space caps it at 32K words
  wire [15:0] x_len_bytes = x_buffer_end_addr - x_buffer_start_addr;
  wire [15:0] y_len_bytes = y_buffer_end_addr - y_buffer_start_addr;
  wire [14:0] x_len_words = x_len_bytes[15:1];
  wire [14:0] y_len_words = y_len_bytes[15:1];

  // x read and write generators share one buffer; y has its own
  logic [15:0] xr_ea;
  logic [15:0] xr_next;
  logic xr_wrap;
  logic [15:0] xw_ea;
  logic [15:0] xw_next;
  logic xw_wrap;
  logic [15:0] y_ea;
  logic [15:0] y_next;
  logic y_wrap;

  // x side takes byte or word steps, also for program-space pointers
  circular_wrap u_x_read (
    .active(x_active),
    .sel(x_sel),
    .word_only(1'b0),
    .start_addr(x_buffer_start_addr),
    .end_addr(x_buffer_end_addr),
    .req(x_rd_req),
    .ea(xr_ea),
    .ptr_next(xr_next),
    .wrapped(xr_wrap)
  );

  circular_wrap u_x_write (
    .active(x_active),
    .sel(x_sel),
    .word_only(1'b0),
    .start_addr(x_buffer_start_addr),
    .end_addr(x_buffer_end_addr),
    .req(x_wr_req),
    .ea(xw_ea),
    .ptr_next(xw_next),
    .wrapped(xw_wrap)
  );

  circular_wrap u_y (
    .active(y_active),
    .sel(y_sel),
    .word_only(1'b1),
    .start_addr(y_buffer_start_addr),
    .end_addr(y_buffer_end_addr),
    .req(y_req),
    .ea(y_ea),
    .ptr_next(y_next),
    .wrapped(y_wrap)
  );

  // response words, assembled combinationally and registered below
  agu_rsp_s next_x_rd_rsp;
  agu_rsp_s next_x_wr_rsp;
  agu_rsp_s next_y_rsp;

  assign next_x_rd_rsp = '{valid: x_rd_req.valid, prog_space: x_rd_req.prog_space,
    wrapped: x_rd_req.valid && xr_wrap, ea: xr_ea, ptr_next: xr_next};
  assign next_x_wr_rsp = '{valid: x_wr_req.valid, prog_space: x_wr_req.prog_space,
    wrapped: x_wr_req.valid && xw_wrap, ea: xw_ea, ptr_next: xw_next};
  assign next_y_rsp = '{valid: y_req.valid, prog_space: 1'b0,
    wrapped: y_req.valid && y_wrap, ea: y_ea, ptr_next: y_next};

  wire x_wrap_event = next_x_rd_rsp.wrapped || next_x_wr_rsp.wrapped;
  wire y_wrap_event = next_y_rsp.wrapped;

  // a status read clears only the flags it latched into prdata;
  // a wrap between its setup and access edges would otherwise be lost
  logic x_wrap_reported;
  logic y_wrap_reported;
  wire x_wrap_clear = read_clears_status && x_wrap_reported;
  wire y_wrap_clear = read_clears_status && y_wrap_reported;

  // sticky wrap flags: a new wrap wins over a clearing read in the same cycle
  wire next_x_wrap_seen = x_wrap_event || (x_wrap_seen && !x_wrap_clear);
  wire next_y_wrap_seen = y_wrap_event || (y_wrap_seen && !y_wrap_clear);

  // status fields; the x length field only has room for eleven bits
  wire [14:0] status_y_len = y_len_words;
  wire [10:0] status_x_len = x_len_words[10:0];
  wire [3:0] status_flags = {y_wrap_seen, x_wrap_seen, y_active, x_active};

  // read data mux
  wire [31:0] status_word = {1'b0, status_y_len, 1'b0, status_x_len, status_flags};
  wire [15:0] rd_reg16 =
    sel_control ? modulo_bitrev_control :
    sel_x_start ? x_buffer_start_addr :
    sel_x_end ? x_buffer_end_addr :
    sel_y_start ? y_buffer_start_addr :
    sel_y_end ? y_buffer_end_addr :
    16'h0000;
  wire [31:0] next_prdata = sel_status ? status_word : {16'h0000, rd_reg16};

  // control register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      modulo_bitrev_control <= `CONTROL_RESET;
    end else if (wr_control) begin
      modulo_bitrev_control <= pwdata[15:0];
    end
  end

  // start and end held apart per space, no length field
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      x_buffer_start_addr <= `ADDR_RESET;
    end else if (wr_x_start) begin
      x_buffer_start_addr <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      x_buffer_end_addr <= `ADDR_RESET;
    end else if (wr_x_end) begin
      x_buffer_end_addr <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      y_buffer_start_addr <= `ADDR_RESET;
    end else if (wr_y_start) begin
      y_buffer_start_addr <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      y_buffer_end_addr <= `ADDR_RESET;
    end else if (wr_y_end) begin
      y_buffer_end_addr <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      x_wrap_seen <= 1'b0;
    end else begin
      x_wrap_seen <= next_x_wrap_seen;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      y_wrap_seen <= 1'b0;
    end else begin
      y_wrap_seen <= next_y_wrap_seen;
    end
  end

  // remember which flags went out with a status read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      x_wrap_reported <= 1'b0;
      y_wrap_reported <= 1'b0;
    end else if (status_setup) begin
      x_wrap_reported <= x_wrap_seen;
      y_wrap_reported <= y_wrap_seen;
    end
  end

  // read data is held until the next read so it stays stable after the access
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end

  // results follow each request by exactly one cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      x_rd_rsp <= '0;
    end else begin
      x_rd_rsp <= next_x_rd_rsp;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      x_wr_rsp <= '0;
    end else begin
      x_wr_rsp <= next_x_wr_rsp;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      y_rsp <= '0;
    end else begin
      y_rsp <= next_y_rsp;
    end
  end

endmodule
`default_nettype wire

// File: modulo_circular_addressing_sva.sv
// concurrent checks on the ports of the circular addressing block
`timescale 1ns/100ps
`default_nettype none
module modulo_circular_addressing_sva (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // address generators
  input wire modulo_pkg::agu_req_s x_rd_req,
  input wire modulo_pkg::agu_rsp_s x_rd_rsp,
  input wire modulo_pkg::agu_req_s x_wr_req,
  input wire modulo_pkg::agu_rsp_s x_wr_rsp,
  input wire modulo_pkg::agu_req_s y_req,
  input wire modulo_pkg::agu_rsp_s y_rsp
);
  import modulo_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_xr_lat;
    x_rd_req.valid |=> x_rd_rsp.valid && x_rd_rsp.ea == $past(x_rd_req.ptr);
  endproperty
  a_xr_lat: assert property (p_xr_lat) else $error("x read response late or wrong ea");
  property p_xr_lin;
    x_rd_rsp.valid && !x_rd_rsp.wrapped |->
      x_rd_rsp.ptr_next == $past(x_rd_req.ptr) + $past(x_rd_req.step);
  endproperty
  a_xr_lin: assert property (p_xr_lin) else $error("x read pointer not linear");
  property p_xw_lin;
    x_wr_rsp.valid && !x_wr_rsp.wrapped |->
      x_wr_rsp.ptr_next == $past(x_wr_req.ptr) + $past(x_wr_req.step);
  endproperty
  a_xw_lin: assert property (p_xw_lin) else $error("x write pointer not linear");
  property p_xr_prog;
    x_rd_req.valid |=> x_rd_rsp.prog_space == $past(x_rd_req.prog_space);
  endproperty
  a_xr_prog: assert property (p_xr_prog) else $error("x program space flag lost");
  property p_y_word;
    y_rsp.valid |-> y_rsp.ea[0] == 1'b0 && y_rsp.ptr_next[0] == 1'b0;
  endproperty
  a_y_word: assert property (p_y_word) else $error("y address not word aligned");
  property p_y_lat;
    !y_req.valid |=> !y_rsp.valid;
  endproperty
  a_y_lat: assert property (p_y_lat) else $error("y response without request");
  property p_wrap_valid;
    x_rd_rsp.wrapped || x_wr_rsp.wrapped |-> $past(x_rd_req.valid || x_wr_req.valid);
  endproperty
  a_wrap_valid: assert property (p_wrap_valid) else $error("wrap without request");
  property p_err;
    pslverr |-> psel && penable && pready;
  endproperty
  a_err: assert property (p_err) else $error("slave error outside access");
  c_xr_wrap: cover property (x_rd_rsp.wrapped);
  c_xw_wrap: cover property (x_wr_rsp.wrapped);
  c_y_wrap: cover property (y_rsp.wrapped);
  c_err: cover property (pslverr);
endmodule
bind modulo_circular_addressing modulo_circular_addressing_sva chk_inst (.clk(clk),
  .arst_n(arst_n), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .x_rd_req(x_rd_req), .x_rd_rsp(x_rd_rsp), .x_wr_req(x_wr_req), .x_wr_rsp(x_wr_rsp),
  .y_req(y_req), .y_rsp(y_rsp));
`default_nettype wire

// File: modulo_circular_addressing_test.sv
// self-checking bench for the circular addressing block
`timescale 1ns/100ps
`default_nettype none
module modulo_circular_addressing_test;
  import modulo_pkg::*;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, d;
  logic er;
  agu_req_s rq [3];
  agu_rsp_s rs [3];
  logic [15:0] sh [5];
  logic [15:0] ctl [5] = '{16'hc053, 16'h0053, 16'hc0ff, 16'h8f53, 16'h4053};
  logic [1:0] ws;
  int fails, n_compared, i, j, k;
  modulo_circular_addressing modulo_circular_addressing_inst (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .x_rd_req(rq[0]), .x_rd_rsp(rs[0]),
    .x_wr_req(rq[1]), .x_wr_rsp(rs[1]), .y_req(rq[2]), .y_rsp(rs[2]));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      end_of_test();
    end
    q = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    // shadow copy tracks only mapped writable words; status is read only
    if (w && a <= 8'h10 && a[1:0] == 0) sh[a >> 2] = v[15:0];
  endtask
  function automatic logic [34:0] model(int k, logic [3:0] sel, logic [15:0] p, st, logic pg);
    logic [15:0] s, e, n;
    logic w, act;
    w = (k == 2);
    s = w ? sh[3] & 16'hfffe : sh[1];
    e = w ? sh[4] & 16'hfffe : sh[2];
    act = w ? sh[0][14] && sh[0][7:4] != 4'hf && sel == sh[0][7:4]
            : sh[0][15] && sh[0][3:0] != 4'hf && sel == sh[0][3:0];
    p[0] = p[0] & !w;
    n = p + st;
    n[0] = n[0] & !w;
    if (act && !st[15] && n > e) return {1'b1, pg & !w, 1'b1, p, s};
    if (act && st[15] && n < s) return {1'b1, pg & !w, 1'b1, p, e};
    return {1'b1, pg & !w, 1'b0, p, n};
  endfunction
  function automatic logic [31:0] stat(logic [1:0] f);
    logic [15:0] xl, yl;
    xl = (sh[2] - sh[1]) >> 1;
    yl = (sh[4] - sh[3]) >> 1;
    return {1'b0, yl[14:0], 1'b0, xl[10:0], f, sh[0][14] && sh[0][7:4] != 4'hf,
            sh[0][15] && sh[0][3:0] != 4'hf};
  endfunction
  task automatic agu(int k, logic [3:0] sel, logic [15:0] p, st, logic pg);
    logic [34:0] e;
    e = model(k, sel, p, st, pg);
    @(posedge clk);
    rq[k] <= {1'b1, pg, sel, p, st};
    @(posedge clk);
    rq[k] <= '0;
    #1;
    chk(rs[k], e, "agu response");
    if (e[32]) ws[k == 2] = 1'b1;
  endtask
  initial begin
    arst_n = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rq = '{default: '0};
    sh = '{16'h00ff, 16'h0, 16'h0, 16'h0, 16'h0};
    ws = '0;
    void'($urandom(92));
    repeat (2) @(posedge clk);
    arst_n <= 1;
    for (i = 0; i < 5; i++) begin
      apb(0, 8'(i * 4), 0);
      chk(q, sh[i], "reset value");
      d = $urandom;
      apb(1, 8'(i * 4), d);
      apb(0, 8'(i * 4), 0);
      chk(q, {16'h0, d[15:0]}, "read back");
    end
    apb(1, 8'h18, $urandom);
    apb(0, 8'h18, 0);
    chk({er, q}, {1'b1, 32'h0}, "unmapped");
    $display("test registers done");
    // x buffer 16 words, y buffer 8 words, both power of two
    apb(1, 8'h04, 32'h1000);
    apb(1, 8'h08, 32'h101e);
    apb(1, 8'h0c, 32'h2000);
    apb(1, 8'h10, 32'h200e);
    for (j = 0; j < 5; j++) begin
      apb(1, 8'h00, {16'h0, ctl[j]});
      apb(0, 8'h14, 0);
      chk(q[1:0], {ctl[j][14] && ctl[j][7:4] != 4'hf, ctl[j][15] && ctl[j][3:0] != 4'hf},
          "status");
      chk(q, stat(ws), "status word");
      ws = '0;
      for (k = 0; k < 3; k++) begin
        agu(k, k < 2 ? 4'h3 : 4'h5, sh[k < 2 ? 2 : 4], 16'h2, 1'b1);
        agu(k, k < 2 ? 4'h3 : 4'h5, sh[k < 2 ? 1 : 3], 16'hfffe, 1'b1);
      end
      for (i = 0; i < 30; i++) begin
        k = $urandom % 3;
        agu(k, $urandom % 2 ? (k < 2 ? 4'h3 : 4'h5) : 4'($urandom),
            sh[k < 2 ? 1 : 3] + 16'(($urandom % (k < 2 ? 16 : 8)) * 2 + $urandom % 2),
            $urandom % 2 ? 16'h2 : 16'hfffe, 1'($urandom));
      end
      $display("test mode %0d done", j);
    end
    // ten-word buffers: x only counts up, y only counts down
    apb(1, 8'h04, 32'h1100);
    apb(1, 8'h08, 32'h1112);
    apb(1, 8'h0c, 32'h2100);
    apb(1, 8'h10, 32'h2112);
    apb(1, 8'h00, 32'hc053);
    for (i = 0; i < 12; i++) begin
      agu(0, 4'h3, 16'h1100 + 16'(i * 2), 16'h2, 1'b0);
      agu(2, 4'h5, 16'h2112 - 16'(i * 2), 16'hfffe, 1'b0);
    end
    apb(0, 8'h14, 0);
    chk(q, stat(ws), "status word");
    ws = '0;
    $display("test one-way buffers done");
    @(posedge clk);
    arst_n <= 0;
    repeat (2) @(posedge clk);
    arst_n <= 1;
    sh = '{16'h00ff, 16'h0, 16'h0, 16'h0, 16'h0};
    ws = '0;
    for (i = 0; i < 5; i++) begin
      apb(0, 8'(i * 4), 0);
      chk(q, sh[i], "reset value after run");
    end
    apb(0, 8'h14, 0);
    chk(q, stat(ws), "status after reset");
    $display("test reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
